// ---- rtl/pcmr_pkg.sv ----
package pcmr_pkg;

    // ==========================================================
    // Register map and reset values
    // ==========================================================
    localparam logic [7:0]  PCMR_PHY_CTRL_OFS   = 8'hec;
    localparam logic [7:0]  PCMR_MISC_CFG_OFS   = 8'hf0;
    localparam logic [31:0] PCMR_PHY_CTRL_RESET = 32'h0000_0008;
    localparam logic [31:0] PCMR_MISC_CFG_RESET = 32'h0000_0800;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PCMR_ROUTE_BIT    = 7;
    localparam int PCMR_OVERRIDE_BIT = 10;
    localparam int PCMR_RDSEL_LSB    = 8;
    localparam int PCMR_REV23_BIT    = 11;

    // ==========================================================
    // Serial EEPROM image byte that feeds the PHY control bits
    // ==========================================================
    localparam logic [7:0] PCMR_EE_PHY_BYTE = 8'h38;

    // ==========================================================
    // Master read commands and the short-burst limit
    // ==========================================================
    localparam logic [3:0] PCMR_CMD_MEM_READ      = 4'h6;
    localparam logic [3:0] PCMR_CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] PCMR_CMD_MEM_READ_MULT = 4'hc;
    localparam logic [7:0] PCMR_SHORT_READ_PHASES = 8'h02;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pcmr_cfg_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } pcmr_cfg_rsp_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } pcmr_ee_load_s;

    typedef struct packed {
        logic       req;
        logic [7:0] phases;
    } pcmr_mst_rd_s;

endpackage

// ---- rtl/pcmr_sync.sv ----
`timescale 1ns/100ps

module pcmr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Asynchronous levels and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Two flip-flops per bit
    // ==========================================================
    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second, never other logic.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                stage1[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                stage1[i]   <= async_in[i];
                sync_out[i] <= stage1[i];
            end
        end
    end

endmodule

// ---- rtl/pcmr_top.sv ----
`timescale 1ns/100ps

module pcmr_top
    import pcmr_pkg::*;
#(
    parameter int IRQ_WIDTH = 32
) (
    // Clock and power-on reset
    input  wire logic                 CORE_CLK_IN,
    input  wire logic                 RESETN_IN,
    // Reset pins from outside, active low
    input  wire logic                 EXPRESS_LINK_RESETN_IN,
    input  wire logic                 GLOBAL_RESET_PIN_N_IN,
    // Configuration access
    input  wire pcmr_cfg_req_s        CFG_REQ_IN,
    output pcmr_cfg_rsp_s             CFG_RSP_OUT,
    // Serial EEPROM loader
    input  wire logic                 EE_PRESENT_IN,
    input  wire pcmr_ee_load_s        EE_LOAD_IN,
    // PHY cable-inactive indicator and its terminal
    input  wire logic                 CABLE_INACTIVE_INDICATOR_IN,
    output logic                      CABLE_INACTIVE_OUT,
    // Link interrupt state and PME request
    input  wire logic [IRQ_WIDTH-1:0] IRQ_EVENT_IN,
    input  wire logic [IRQ_WIDTH-1:0] IRQ_MASK_IN,
    input  wire logic                 MASTER_IRQ_GATE_IN,
    output logic                      PME_REQ_OUT,
    output logic                      LINK_VID_BIT26_OUT,
    // PCI master read command selection
    input  wire pcmr_mst_rd_s         MST_RD_IN,
    output logic                      MST_CMD_VALID_OUT,
    output logic [3:0]                MST_CMD_OUT
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic          route_en;
        logic [4:0]    phy_low;
        logic          pme_gating_override;
        logic [1:0]    read_cmd_select;
        pcmr_cfg_rsp_s rsp;
        logic          cable_out;
        logic          pme_req;
        logic          cmd_valid;
        logic [3:0]    cmd;
    } pcmr_state_s;

    pcmr_state_s st;
    pcmr_state_s next_st;
    logic [2:0]  sync_q;
    logic        soft_rst_n;
    logic        cna_s;
    logic [31:0] phy_word;
    logic [31:0] misc_word;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    pcmr_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_in    (CORE_CLK_IN),
        .resetn_in (RESETN_IN),
        .async_in  ({CABLE_INACTIVE_INDICATOR_IN,
                     GLOBAL_RESET_PIN_N_IN,
                     EXPRESS_LINK_RESETN_IN}),
        .sync_out  (sync_q)
    );

    // Either reset pin returns the writable bits to defaults.
    assign soft_rst_n = sync_q[0] & sync_q[1];
    assign cna_s      = sync_q[2];

    // ==========================================================
    // Read images
    // ==========================================================
    // Only stored bits appear; every other position is a constant.
    always_comb begin
        phy_word                 = 32'h0000_0000;
        phy_word[PCMR_ROUTE_BIT] = st.route_en;
        phy_word[4:0]            = st.phy_low;
        misc_word                = 32'h0000_0000;
        misc_word[PCMR_REV23_BIT]    = 1'b1;
        misc_word[PCMR_OVERRIDE_BIT] = st.pme_gating_override;
        misc_word[PCMR_RDSEL_LSB +: 2] = st.read_cmd_select;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    // The EEPROM load is applied first so that a configuration
    // write in the same cycle has the last word.
    always_comb begin
        next_st = st;
        next_st.rsp.ack   = 1'b0;
        next_st.rsp.rdata = 32'h0000_0000;
        if (EE_PRESENT_IN && EE_LOAD_IN.valid &&
            EE_LOAD_IN.addr == PCMR_EE_PHY_BYTE) begin
            next_st.route_en = EE_LOAD_IN.data[PCMR_ROUTE_BIT];
            next_st.phy_low  = EE_LOAD_IN.data[4:0];
        end
        if (CFG_REQ_IN.valid) begin
            next_st.rsp.ack = 1'b1;
            if (CFG_REQ_IN.offset == PCMR_PHY_CTRL_OFS) begin
                if (!CFG_REQ_IN.write) begin
                    next_st.rsp.rdata = phy_word;
                end else if (CFG_REQ_IN.byte_en[0]) begin
                    // Upper bytes are fixed and simply dropped.
                    next_st.route_en =
                        CFG_REQ_IN.wdata[PCMR_ROUTE_BIT];
                    next_st.phy_low  = CFG_REQ_IN.wdata[4:0];
                end
            end else if (CFG_REQ_IN.offset == PCMR_MISC_CFG_OFS) begin
                if (!CFG_REQ_IN.write) begin
                    next_st.rsp.rdata = misc_word;
                end else if (CFG_REQ_IN.byte_en[1]) begin
                    next_st.pme_gating_override =
                        CFG_REQ_IN.wdata[PCMR_OVERRIDE_BIT];
                    next_st.read_cmd_select =
                        CFG_REQ_IN.wdata[PCMR_RDSEL_LSB +: 2];
                end
            end
        end
        // Pin reset overrides everything stored by software.
        if (!soft_rst_n) begin
            next_st.route_en = PCMR_PHY_CTRL_RESET[PCMR_ROUTE_BIT];
            next_st.phy_low  = PCMR_PHY_CTRL_RESET[4:0];
            next_st.pme_gating_override =
                PCMR_MISC_CFG_RESET[PCMR_OVERRIDE_BIT];
            next_st.read_cmd_select =
                PCMR_MISC_CFG_RESET[PCMR_RDSEL_LSB +: 2];
        end
        // Terminal follows the indicator only while routed.
        next_st.cable_out = st.route_en & cna_s;
        // Without override the master gate qualifies PME.
        next_st.pme_req = (|(IRQ_EVENT_IN & IRQ_MASK_IN)) &
                          (st.pme_gating_override |
                           MASTER_IRQ_GATE_IN);
        next_st.cmd_valid = MST_RD_IN.req;
        if (MST_RD_IN.phases <= PCMR_SHORT_READ_PHASES) begin
            next_st.cmd = PCMR_CMD_MEM_READ;
        end else begin
            case (st.read_cmd_select)
                2'h1:    next_st.cmd = PCMR_CMD_MEM_READ;
                2'h2:    next_st.cmd = PCMR_CMD_MEM_READ_MULT;
                default: next_st.cmd = PCMR_CMD_MEM_READ_LINE;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st          <= '0;
            st.phy_low  <= PCMR_PHY_CTRL_RESET[4:0];
            st.route_en <= PCMR_PHY_CTRL_RESET[PCMR_ROUTE_BIT];
            st.pme_gating_override <=
                PCMR_MISC_CFG_RESET[PCMR_OVERRIDE_BIT];
            st.read_cmd_select <=
                PCMR_MISC_CFG_RESET[PCMR_RDSEL_LSB +: 2];
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign CFG_RSP_OUT        = st.rsp;
    assign CABLE_INACTIVE_OUT = st.cable_out;
    assign PME_REQ_OUT        = st.pme_req;
    assign LINK_VID_BIT26_OUT = st.pme_gating_override;
    assign MST_CMD_VALID_OUT  = st.cmd_valid;
    assign MST_CMD_OUT        = st.cmd;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    logic rd_phy;
    logic rd_misc;
    logic wr_misc;
    assign rd_phy  = CFG_REQ_IN.valid && !CFG_REQ_IN.write &&
                     CFG_REQ_IN.offset == PCMR_PHY_CTRL_OFS;
    assign rd_misc = CFG_REQ_IN.valid && !CFG_REQ_IN.write &&
                     CFG_REQ_IN.offset == PCMR_MISC_CFG_OFS;
    assign wr_misc = CFG_REQ_IN.valid && CFG_REQ_IN.write &&
                     CFG_REQ_IN.offset == PCMR_MISC_CFG_OFS &&
                     CFG_REQ_IN.byte_en[1];

    chk_phy_upper_zero: assert property (
        rd_phy |=> CFG_RSP_OUT.ack && CFG_RSP_OUT.rdata[31:8] == 24'h0)
        else $error("PHY control upper bits not zero");
    chk_phy_gap_zero: assert property (
        rd_phy |=> CFG_RSP_OUT.rdata[6:5] == 2'h0)
        else $error("PHY control bits 6..5 not zero");
    chk_misc_upper_zero: assert property (
        rd_misc |=> CFG_RSP_OUT.rdata[31:16] == 16'h0)
        else $error("Misc upper bits not zero");
    chk_misc_cold_pme: assert property (
        rd_misc |=> !CFG_RSP_OUT.rdata[15])
        else $error("Misc bit 15 not zero");
    chk_misc_rsvd_zero: assert property (
        rd_misc |=> CFG_RSP_OUT.rdata[14:12] == 3'h0)
        else $error("Misc bits 14..12 not zero");
    chk_misc_rev23_one: assert property (
        rd_misc |=> CFG_RSP_OUT.rdata[11])
        else $error("Misc bit 11 not one");
    chk_ee_route_load: assert property (
        EE_PRESENT_IN && EE_LOAD_IN.valid && soft_rst_n &&
        EE_LOAD_IN.addr == PCMR_EE_PHY_BYTE && !CFG_REQ_IN.valid
        |=> st.route_en == $past(EE_LOAD_IN.data[7]))
        else $error("EEPROM load of route enable lost");
    chk_route_terminal: assert property (
        !st.route_en [*2] |-> !CABLE_INACTIVE_OUT)
        else $error("Indicator driven while not routed");
    chk_mirror_write: assert property (
        wr_misc && soft_rst_n
        |=> LINK_VID_BIT26_OUT == $past(CFG_REQ_IN.wdata[10]))
        else $error("Vendor bit 26 does not mirror override");
    chk_pme_gated: assert property (
        !st.pme_gating_override && !MASTER_IRQ_GATE_IN |=> !PME_REQ_OUT)
        else $error("PME raised without master gate");
    chk_short_read_cmd: assert property (
        MST_RD_IN.req && MST_RD_IN.phases <= PCMR_SHORT_READ_PHASES
        |=> MST_CMD_VALID_OUT && MST_CMD_OUT == PCMR_CMD_MEM_READ)
        else $error("Short master read not plain memory read");
    chk_pin_reset_default: assert property (
        !soft_rst_n |=> st.phy_low == 5'h08 && !st.route_en &&
                        !LINK_VID_BIT26_OUT)
        else $error("Pin reset did not restore defaults");

    cov_misc_write: cover property (wr_misc ##1 LINK_VID_BIT26_OUT);
    cov_routed: cover property (st.route_en && CABLE_INACTIVE_OUT);
    cov_long_mult: cover property (
        MST_CMD_VALID_OUT && MST_CMD_OUT == PCMR_CMD_MEM_READ_MULT);

endmodule

// ---- tb/phy_ctrl_misc_config_regs_tb.sv ----
`timescale 1ns/100ps

module phy_ctrl_misc_config_regs_tb
    import pcmr_pkg::*;
;
    // ==========================================================
    // Signals and reference model state
    // ==========================================================
    logic          clk, rstn, el_rstn, gl_rstn, ee_pres, cin, cout;
    logic          gate, pme, vid, mv;
    logic [31:0]   ev, mk, rdv;
    logic [3:0]    mc;
    pcmr_cfg_req_s req;
    pcmr_cfg_rsp_s rsp;
    pcmr_ee_load_s ee;
    pcmr_mst_rd_s  mrd;
    int            miscompares, cmp_count, phy_m, misc_m, i, s, ph;
    logic [3:0]    cmd_q[$];

    pcmr_top #(.IRQ_WIDTH(32)) u_pcmr_top (
        .CORE_CLK_IN(clk), .RESETN_IN(rstn),
        .EXPRESS_LINK_RESETN_IN(el_rstn), .GLOBAL_RESET_PIN_N_IN(gl_rstn),
        .CFG_REQ_IN(req), .CFG_RSP_OUT(rsp),
        .EE_PRESENT_IN(ee_pres), .EE_LOAD_IN(ee),
        .CABLE_INACTIVE_INDICATOR_IN(cin), .CABLE_INACTIVE_OUT(cout),
        .IRQ_EVENT_IN(ev), .IRQ_MASK_IN(mk), .MASTER_IRQ_GATE_IN(gate),
        .PME_REQ_OUT(pme), .LINK_VID_BIT26_OUT(vid),
        .MST_RD_IN(mrd), .MST_CMD_VALID_OUT(mv), .MST_CMD_OUT(mc)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Counts every comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One access: request for one cycle, answer stands the next cycle.
    task automatic access(input logic w, input logic [7:0] ofs,
                          input logic [3:0] be, input logic [31:0] wd);
        @(posedge clk);
        #1 req = '{1'b1, w, ofs, be, wd};
        @(posedge clk);
        #1 req.valid = 1'b0;
        check({31'h0, rsp.ack}, 32'h1);
        rdv = rsp.rdata;
    endtask

    // Writes follow the model: only writable bits of an enabled byte move.
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be,
                      input logic [31:0] wd);
        access(1'b1, ofs, be, wd);
        if (ofs == PCMR_PHY_CTRL_OFS && be[0]) phy_m = wd & 32'h9f;
        if (ofs == PCMR_MISC_CFG_OFS && be[1])
            misc_m = (wd & 32'h700) | 32'h800;
    endtask

    task automatic rd_chk(input logic [7:0] ofs);
        logic [31:0] e;
        e = (ofs == PCMR_PHY_CTRL_OFS) ? phy_m :
            (ofs == PCMR_MISC_CFG_OFS) ? misc_m : 32'h0;
        access(1'b0, ofs, 4'hf, 32'h0);
        check(rdv, e);
    endtask

    task automatic ee_load(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 ee = '{1'b1, a, d};
        @(posedge clk);
        #1 ee.valid = 1'b0;
    endtask

    // Pulses one reset pin long enough to pass its synchroniser.
    task automatic reset_pin(input int which);
        @(posedge clk);
        #1 if (which == 0) el_rstn = 1'b0; else gl_rstn = 1'b0;
        repeat (5) @(posedge clk);
        #1 el_rstn = 1'b1;
        gl_rstn = 1'b1;
        repeat (4) @(posedge clk);
        phy_m  = 32'h8;
        misc_m = 32'h800;
    endtask

    function automatic logic [3:0] exp_cmd(input int sel, input int n);
        if (n <= 2) return PCMR_CMD_MEM_READ;
        case (sel)
            1:       return PCMR_CMD_MEM_READ;
            2:       return PCMR_CMD_MEM_READ_MULT;
            default: return PCMR_CMD_MEM_READ_LINE;
        endcase
    endfunction

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog and tests
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The tests need a few hundred cycles; this leaves wide margin.
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    initial begin
        {rstn, ee_pres, cin, gate} = 4'h0;
        {el_rstn, gl_rstn} = 2'b11;
        {req, ee, mrd, ev, mk} = '0;
        {miscompares, cmp_count} = 0;
        phy_m  = 32'h8;
        misc_m = 32'h800;
        void'($urandom(3));
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(PCMR_PHY_CTRL_OFS);
        rd_chk(PCMR_MISC_CFG_OFS);
        check({31'h0, vid}, 32'h0);
        $display("test reset values done");
        // Reserved writable bits stay zero; bits 6 and 5 are read-only.
        wr(PCMR_PHY_CTRL_OFS, 4'hf, 32'hffffff68);
        rd_chk(PCMR_PHY_CTRL_OFS);
        wr(PCMR_PHY_CTRL_OFS, 4'he, 32'h00000080);
        rd_chk(PCMR_PHY_CTRL_OFS);
        wr(PCMR_MISC_CFG_OFS, 4'hf, 32'hfffff7ff);
        check({31'h0, vid}, 32'h1);
        rd_chk(PCMR_MISC_CFG_OFS);
        wr(PCMR_MISC_CFG_OFS, 4'hd, 32'h0);
        rd_chk(PCMR_MISC_CFG_OFS);
        rd_chk(8'he8);
        wr(PCMR_MISC_CFG_OFS, 4'h2, 32'h0);
        check({31'h0, vid}, 32'h0);
        $display("test register access done");
        // Images keep bit 3 set and bit 1 clear.
        ee_pres = 1'b1;
        ee_load(8'h39, 8'h88);
        rd_chk(PCMR_PHY_CTRL_OFS);
        ee_pres = 1'b0;
        ee_load(PCMR_EE_PHY_BYTE, 8'h88);
        rd_chk(PCMR_PHY_CTRL_OFS);
        ee_pres = 1'b1;
        ee_load(PCMR_EE_PHY_BYTE, 8'h88);
        phy_m = 32'h88;
        rd_chk(PCMR_PHY_CTRL_OFS);
        $display("test eeprom load done");
        for (i = 0; i < 8; i++) begin
            if (i == 4) wr(PCMR_PHY_CTRL_OFS, 4'h1, 32'h8);
            @(posedge clk);
            #1 cin = ~cin;
            repeat (5) @(posedge clk);
            #1 check({31'h0, cout}, {31'h0, cin & phy_m[7]});
        end
        $display("test cable terminal done");
        for (i = 0; i < 32; i++) begin
            if (i % 8 == 0) wr(PCMR_MISC_CFG_OFS, 4'h2, {21'h0, i[3], 10'h0});
            @(posedge clk);
            #1 ev = $urandom;
            mk = (i % 4 == 0) ? 32'h0 : $urandom;
            gate = 1'($urandom);
            @(posedge clk);
            #1 check({31'h0, pme},
                     {31'h0, (|(ev & mk)) & (misc_m[10] | gate)});
        end
        $display("test pme done");
        for (s = 0; s < 4; s++) begin
            wr(PCMR_MISC_CFG_OFS, 4'h2, 32'(s) << 8);
            for (i = 0; i < 4; i++) begin
                ph = (i < 3) ? i + 1 : 3 + $urandom % 250;
                @(posedge clk);
                #1 mrd = '{1'b1, 8'(ph)};
                cmd_q.push_back(exp_cmd(s, ph));
                @(posedge clk);
                #1 mrd.req = 1'b0;
                check({31'h0, mv}, 32'h1);
                check({28'h0, mc}, {28'h0, cmd_q.pop_front()});
            end
        end
        $display("test master read done");
        for (s = 0; s < 2; s++) begin
            wr(PCMR_PHY_CTRL_OFS, 4'h1, 32'h88);
            wr(PCMR_MISC_CFG_OFS, 4'h2, 32'h700);
            reset_pin(s);
            rd_chk(PCMR_PHY_CTRL_OFS);
            rd_chk(PCMR_MISC_CFG_OFS);
        end
        $display("test reset pins done");
        end_sim();
    end
endmodule
